// ### bench/ssc_video_src.sv
`timescale 1ns/1ps
// graphics source model: 12-bit words on both link edges, about 160 ns per pixel
module ssc_video_src (
  input wire logic sys_clk_in,
  input wire logic edge_strap_in,
  output logic video_clock_in_pos_out,
  output logic [11:0] video_word_out,
  output logic video_data_valid_out,
  output logic video_hsync_out,
  output logic video_vsync_out
);
  logic [25:0] pend[$];
  logic [25:0] cur;

  // items are {vsync, hsync, pixel}
  function automatic void push(input logic [25:0] item);
    pend.push_back(item);
  endfunction

  // one pixel per pass; the link clock rests at its idle level between frames
  initial begin
    video_clock_in_pos_out = 1'b0;
    video_word_out = 12'h0000;
    video_data_valid_out = 1'b0;
    video_hsync_out = 1'b0;
    video_vsync_out = 1'b0;
    forever begin
      @(posedge sys_clk_in);
      if (pend.size() == 0) begin
        video_clock_in_pos_out <= edge_strap_in;
        video_data_valid_out <= 1'b0;
        // released bus toggles so stale data never looks valid
        video_word_out <= ~video_word_out;
        video_hsync_out <= 1'b0;
        video_vsync_out <= 1'b0;
      end else begin
        cur = pend.pop_front();
        // low half ahead of the edge the strap names
        video_word_out <= cur[11:0];
        video_data_valid_out <= 1'b1;
        video_hsync_out <= cur[24];
        video_vsync_out <= cur[25];
        repeat (10) @(posedge sys_clk_in);
        video_clock_in_pos_out <= ~edge_strap_in;
        repeat (10) @(posedge sys_clk_in);
        // words held ten cycles either side of every edge
        video_word_out <= cur[23:12];
        repeat (10) @(posedge sys_clk_in);
        video_clock_in_pos_out <= edge_strap_in;
        repeat (9) @(posedge sys_clk_in);
      end
    end
  end
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb;
  logic clk = 1'b0, rstn = 1'b0, ref_clk = 1'b0, edge_strap = 1'b0, programmed = 1'b0;
  logic panel_6bit = 1'b0, dither_en = 1'b0, link_clk, de, hs, vs, pv, prim, sact, byp, mok;
  logic ext, lck1, lck2, phs, pvs;
  logic [1:0] port_strap = 2'h0, sync_mode = 2'h0, amode;
  logic [11:0] word;
  logic [3:0] lanes1, lanes2;
  logic [23:0] exp_q[$];
  ssc_pkg::ssc_in_timing_s timing = '0;
  ssc_pkg::ssc_pixel_s pix;
  int n_fail = 0, total_checks = 0;
  // pixels sent since the last reset; sets the expected dither phase
  int n_px = 0;
  logic [23:0] exp_px;

  always #2 clk = ~clk;
  // reference clock near 14.3 mhz, unrelated to the system clock
  always #35 ref_clk = ~ref_clk;

  ssc_video_src ssc_video_src_inst (.sys_clk_in(clk), .edge_strap_in(edge_strap),
    .video_clock_in_pos_out(link_clk), .video_word_out(word), .video_data_valid_out(de),
    .video_hsync_out(hs), .video_vsync_out(vs));

  ssc_display_sync ssc_display_sync_inst (.sys_clk_in(clk), .rstn_in(rstn),
    .video_clock_in_pos_in(link_clk), .video_word_in(word), .video_data_valid_in(de),
    .video_hsync_in(hs), .video_vsync_in(vs), .ref_clock_in(ref_clk),
    .edge_strap_in(edge_strap), .port_strap_in(port_strap), .in_timing_in(timing),
    .programmed_in(programmed), .sync_mode_in(sync_mode), .panel_6bit_in(panel_6bit),
    .dither_en_in(dither_en), .out_pixel_total_in(12'h0009), .out_line_total_in(12'h0003),
    .out_hsync_width_in(12'h0002), .out_vsync_width_in(12'h0001), .pixel_out(pix),
    .pixel_valid_out(pv), .primary_capture_edge_out(prim), .scaler_active_out(sact),
    .bypass_out(byp), .input_mode_ok_out(mok), .active_sync_mode_out(amode),
    .panel_hsync_out(phs), .panel_vsync_out(pvs), .lvds_lanes_first_out(lanes1),
    .lvds_lanes_second_out(lanes2), .lvds_clock_first_out(lck1),
    .lvds_clock_second_out(lck2), .extra_edges_out(ext));

  task automatic conclude();
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // every valid pulse is matched against the model queue in order
  always @(posedge clk) begin
    if (rstn === 1'b1 && pv === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK("spurious pixel", 1'b0, 1'b1)
      end else begin
        exp_px = exp_q.pop_front();
        `CHK("pixel_out", exp_px, pix)
      end
    end
  end

  // model: scaled path dithers lsbs with a per-pixel phase; six-bit panels lose the lsbs
  function automatic logic [23:0] model_px(input logic [23:0] px);
    logic [1:0] ph;
    ph = 2'(n_px);
    n_px++;
    if (dither_en && programmed && port_strap != 2'h3) begin
      px = px ^ {6'h00, ph, 6'h00, ph, 6'h00, ph};
    end
    return panel_6bit ? (px & 24'hfc_fcfc) : px;
  endfunction

  task automatic send(input int n);
    logic [23:0] px;
    int w;
    // let settings driven just before the call reach the design and the model
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      px = 24'($urandom);
      ssc_video_src_inst.push({i == 0, i == 0, px});
      exp_q.push_back(model_px(px));
    end
    for (w = 0; w < n * 60 + 100 && exp_q.size() > 0; w++) @(posedge clk);
    if (exp_q.size() > 0) begin
      `CHK("pixel count", 1'b0, 1'b1)
      conclude();
    end
  endtask

  task automatic do_reset(input logic edge_sel);
    rstn <= 1'b0;
    n_px = 0;
    edge_strap <= edge_sel;
    repeat (1) @(posedge clk);
    #1;
    `CHK("bypass in reset", 1'b1, byp)
    `CHK("valid in reset", 1'b0, pv)
    @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("primary edge", edge_sel, prim)
  endtask

  // strap decoding for lanes, clocks, scaler and extra capture edges
  task automatic chk_strap(input logic [1:0] s);
    port_strap <= s;
    repeat (600) @(posedge clk);
    #1;
    `CHK("lanes first", ssc_pkg::SSC_LANES_ON, lanes1)
    `CHK("lanes second", (s == 2'h0) ? ssc_pkg::SSC_LANES_OFF : ssc_pkg::SSC_LANES_ON, lanes2)
    `CHK("extra edges", s == 2'h1, ext)
    `CHK("scaler", s != 2'h3, sact)
    `CHK("bypass", s == 2'h3, byp)
    `CHK("clock first", edge_strap, lck1)
    `CHK("clock second", (s != 2'h0) & edge_strap, lck2)
  endtask

  // waits for the selector to be adopted, bounded by just over four free-run frames of 700 cycles
  task automatic wait_mode(input logic [1:0] m);
    int w;
    for (w = 0; w < 3000 && amode !== m; w++) @(posedge clk);
    `CHK("mode adopted", m, amode)
    if (amode !== m) conclude();
  endtask

  initial begin
    int rises;
    int w;
    logic prev;
    void'($urandom(32'hbb9c));
    timing = '{12'h000a, 12'h0002, 12'h0064, 12'h0014, 12'h0014, 12'h005a};
    do_reset(1'b0);
    programmed <= 1'b1;
    chk_strap(2'h1);
    chk_strap(2'h3);
    chk_strap(2'h0);
    `CHK("input mode ok", 1'b1, mok)
    send(6);
    // eight-bit panel with dither on: lsbs follow the per-pixel phase
    dither_en <= 1'b1;
    send(4);
    // dither setting must not reach the two lsbs
    panel_6bit <= 1'b1;
    dither_en <= 1'($urandom);
    send(6);
    panel_6bit <= 1'b0;
    dither_en <= 1'b1;
    port_strap <= 2'h3;
    repeat (4) @(posedge clk);
    send(4);
    dither_en <= 1'b0;
    port_strap <= 2'h0;
    programmed <= 1'b0;
    repeat (600) @(posedge clk);
    #1;
    `CHK("scaler unprogrammed", 1'b0, sact)
    `CHK("mode ok unprogrammed", 1'b0, mok)
    programmed <= 1'b1;
    do_reset(1'b1);
    send(4);
    // ten reference ticks per panel line in free run
    rises = 0;
    prev = phs;
    repeat (1750) begin
      @(posedge clk);
      if (prev === 1'b0 && phs === 1'b1) rises++;
      prev = phs;
    end
    `CHK("hsync lines", 1'b1, rises >= 9 && rises <= 11)
    sync_mode <= 2'h2;
    repeat (1000) @(posedge clk);
    `CHK("mode two ignored", ssc_pkg::SSC_SYNC_FREE, amode)
    // move the selector just after a frame start, far from the next boundary
    for (w = 0; w < 800 && pvs !== 1'b0; w++) @(posedge clk);
    for (w = 0; w < 800 && pvs !== 1'b1; w++) @(posedge clk);
    `CHK("frame start", 1'b1, pvs)
    if (pvs !== 1'b1) conclude();
    sync_mode <= ssc_pkg::SSC_SYNC_FRAME;
    repeat (3) @(posedge clk);
    #1;
    `CHK("mode held", ssc_pkg::SSC_SYNC_FREE, amode)
    wait_mode(ssc_pkg::SSC_SYNC_FRAME);
    send(2);
    sync_mode <= ssc_pkg::SSC_SYNC_LINE;
    wait_mode(ssc_pkg::SSC_SYNC_LINE);
    // line lock keeps taking pixels from the link
    send(3);
    conclude();
  end
endmodule

// ### logic/ssc_display_sync.sv
`timescale 1ns/1ps
// Contract
// - single-port words are assembled into 24-bit or 18-bit rgb pixels.
// - bypass scaling above 108 mhz single-port or with dual-port input.
// - host input timing values are held and used to judge input mode.
// - free-run derives output timing from reference clock and registers only.
// - line-lock restarts panel hsync on each input line.
// - frame-lock keeps reference hsync but restarts vsync per input frame.
// - exactly three sync modes, no frame store.
// - 6-bit panels: dither optional, else two lsbs forced low; here the two lsbs are forced low with dither on too.
// - 8-bit panels: dithering may be switched off.
// - input data captured on both video clock edges.
// - edge strap picks rising or falling as primary capture edge.
// - strap at ground enables first four lanes and first clock only.
// - strap at supply enables all lanes, both clocks, scaler off.
// - lower pixel half on primary edge, upper half on opposite edge.
// - third and fourth edges used only in single-in dual-out.
module ssc_display_sync (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic video_clock_in_pos_in,
  input wire logic [11:0] video_word_in,
  input wire logic video_data_valid_in,
  input wire logic video_hsync_in,
  input wire logic video_vsync_in,
  input wire logic ref_clock_in,
  input wire logic edge_strap_in,
  input wire logic [1:0] port_strap_in,
  input wire ssc_pkg::ssc_in_timing_s in_timing_in,
  input wire logic programmed_in,
  input wire logic [1:0] sync_mode_in,
  input wire logic panel_6bit_in,
  input wire logic dither_en_in,
  input wire logic [11:0] out_pixel_total_in,
  input wire logic [11:0] out_line_total_in,
  input wire logic [11:0] out_hsync_width_in,
  input wire logic [11:0] out_vsync_width_in,
  output ssc_pkg::ssc_pixel_s pixel_out,
  output logic pixel_valid_out,
  output logic primary_capture_edge_out,
  output logic scaler_active_out,
  output logic bypass_out,
  output logic input_mode_ok_out,
  output logic [1:0] active_sync_mode_out,
  output logic panel_hsync_out,
  output logic panel_vsync_out,
  output logic [3:0] lvds_lanes_first_out,
  output logic [3:0] lvds_lanes_second_out,
  output logic lvds_clock_first_out,
  output logic lvds_clock_second_out,
  output logic extra_edges_out
);
  logic vclk_lvl, vclk_rise, vclk_fall;
  logic ref_rise;
  logic de_s1, de_s2, hs_s1, hs_s2, hs_prev, vs_s1, vs_s2, vs_prev;
  logic [11:0] word_s1, word_s2;

  // link clock and its edges in the system domain
  ssc_edge_sync u_vclk (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .async_in(video_clock_in_pos_in),
    .level_out(vclk_lvl),
    .rise_out(vclk_rise),
    .fall_out(vclk_fall)
  );

  ssc_edge_sync u_ref (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .async_in(ref_clock_in),
    .level_out(),
    .rise_out(ref_rise),
    .fall_out()
  );

  // two-flop sampling of video data and syncs; leads the clock path by one cycle
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      word_s1 <= 12'h0000;
      word_s2 <= 12'h0000;
      de_s1 <= 1'b0;
      de_s2 <= 1'b0;
      hs_s1 <= 1'b0;
      hs_s2 <= 1'b0;
      hs_prev <= 1'b0;
      vs_s1 <= 1'b0;
      vs_s2 <= 1'b0;
      vs_prev <= 1'b0;
    end else begin
      word_s1 <= video_word_in;
      word_s2 <= word_s1;
      de_s1 <= video_data_valid_in;
      de_s2 <= de_s1;
      hs_s1 <= video_hsync_in;
      hs_s2 <= hs_s1;
      hs_prev <= hs_s2;
      vs_s1 <= video_vsync_in;
      vs_s2 <= vs_s1;
      vs_prev <= vs_s2;
    end
  end

  wire in_line_start = hs_s2 & ~hs_prev;
  wire in_frame_start = vs_s2 & ~vs_prev;
  wire is_dual = (port_strap_in == ssc_pkg::SSC_PORT_DUAL);
  wire is_sido = (port_strap_in == ssc_pkg::SSC_PORT_SIDO);

  // ---- capture: primary and opposite edges ----
  logic prim_edge, opp_edge;
  logic [11:0] low_half, next_low_half;
  ssc_pkg::ssc_pixel_s cap_pix, next_cap_pix;
  logic cap_valid, next_cap_valid;
  logic edge_sel, next_edge_sel;

  // strap is resampled every cycle after reset release, never under async reset
  // strap selects edge
  assign prim_edge = edge_sel ? vclk_fall : vclk_rise;
  assign opp_edge = edge_sel ? vclk_rise : vclk_fall;

  always_comb begin
    next_edge_sel = edge_strap_in;
    next_low_half = low_half;
    next_cap_pix = cap_pix;
    next_cap_valid = 1'b0;
    if (prim_edge) begin
      next_low_half = word_s2;
    end
    // assemble 24-bit pixel, upper half on opposite edge
    if (opp_edge && de_s2) begin
      next_cap_pix.red = word_s2[11:4];
      next_cap_pix.green = {word_s2[3:0], low_half[11:8]};
      next_cap_pix.blue = low_half[7:0];
      next_cap_valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      edge_sel <= 1'b0;
      low_half <= 12'h0000;
      cap_pix <= '0;
      cap_valid <= 1'b0;
    end else begin
      edge_sel <= next_edge_sel;
      low_half <= next_low_half;
      cap_pix <= next_cap_pix;
      cap_valid <= next_cap_valid;
    end
  end

  // ---- input rate measurement and bypass decision ----
  logic [11:0] meas_cyc, next_meas_cyc, edge_cnt, next_edge_cnt;
  logic too_fast, next_too_fast;

  always_comb begin
    next_meas_cyc = meas_cyc + ssc_pkg::SSC_CNT_ONE;
    next_edge_cnt = vclk_rise ? edge_cnt + ssc_pkg::SSC_CNT_ONE : edge_cnt;
    next_too_fast = too_fast;
    if (meas_cyc == 12'(ssc_pkg::SSC_MEAS_CYC - 1)) begin
      next_meas_cyc = ssc_pkg::SSC_CNT_ZERO;
      next_edge_cnt = ssc_pkg::SSC_CNT_ZERO;
      next_too_fast = (edge_cnt > ssc_pkg::SSC_BYPASS_EDGES);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meas_cyc <= 12'h0000;
      edge_cnt <= 12'h0000;
      too_fast <= 1'b0;
    end else begin
      meas_cyc <= next_meas_cyc;
      edge_cnt <= next_edge_cnt;
      too_fast <= next_too_fast;
    end
  end

  // programmed timing must be self-consistent to count as a known mode
  wire mode_ok = programmed_in
    && (in_timing_in.active_end > in_timing_in.active_start)
    && (in_timing_in.active_end <= in_timing_in.pixel_total)
    && (in_timing_in.hsync_width < in_timing_in.pixel_total)
    && (in_timing_in.vsync_width < in_timing_in.line_total);
  // bypass when too fast or dual-port
  // scaler shut down in dual mode
  wire scale_on = mode_ok && !too_fast && !is_dual;

  // ---- output timing generator ----
  ssc_pkg::ssc_sync_e cur_mode, next_cur_mode;
  logic [11:0] hcnt, next_hcnt, vcnt, next_vcnt;
  logic frame_end;

  assign frame_end = (vcnt == out_line_total_in) && (hcnt == out_pixel_total_in);

  always_comb begin
    logic line_tick;
    logic frame_restart;
    line_tick = 1'b0;
    frame_restart = 1'b0;
    next_hcnt = hcnt;
    next_vcnt = vcnt;
    next_cur_mode = cur_mode;
    unique case (cur_mode)
      ssc_pkg::SSC_SYNC_FREE: begin
        line_tick = ref_rise && (hcnt == out_pixel_total_in);
      end
      ssc_pkg::SSC_SYNC_LINE: begin
        line_tick = in_line_start;
      end
      // reference hsync, vsync restarted per input frame
      ssc_pkg::SSC_SYNC_FRAME: begin
        line_tick = ref_rise && (hcnt == out_pixel_total_in);
        frame_restart = in_frame_start;
      end
      default: begin
        line_tick = 1'b0;
      end
    endcase
    if (cur_mode != ssc_pkg::SSC_SYNC_LINE && ref_rise && !line_tick) begin
      next_hcnt = hcnt + ssc_pkg::SSC_CNT_ONE;
    end
    if (line_tick) begin
      next_hcnt = ssc_pkg::SSC_CNT_ZERO;
      next_vcnt = (vcnt >= out_line_total_in) ? ssc_pkg::SSC_CNT_ZERO
                                              : vcnt + ssc_pkg::SSC_CNT_ONE;
    end else if (cur_mode == ssc_pkg::SSC_SYNC_LINE && vclk_rise) begin
      next_hcnt = hcnt + ssc_pkg::SSC_CNT_ONE;
    end
    if (frame_restart) begin
      next_vcnt = ssc_pkg::SSC_CNT_ZERO;
    end
    // adopt selector only at frame boundary
    if ((frame_end || frame_restart) && (sync_mode_in == ssc_pkg::SSC_SYNC_FREE
        || sync_mode_in == ssc_pkg::SSC_SYNC_LINE
        || sync_mode_in == ssc_pkg::SSC_SYNC_FRAME)) begin
      next_cur_mode = ssc_pkg::ssc_sync_e'(sync_mode_in);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cur_mode <= ssc_pkg::SSC_SYNC_FREE;
      hcnt <= 12'h0000;
      vcnt <= 12'h0000;
    end else begin
      cur_mode <= next_cur_mode;
      hcnt <= next_hcnt;
      vcnt <= next_vcnt;
    end
  end

  // ---- colour path, dither and outputs ----
  logic [1:0] dith_phase;
  ssc_pkg::ssc_pixel_s next_pix;

  // dither only on scaled path; six-bit panels truncate either way
  always_comb begin
    next_pix = cap_pix;
    if (scale_on && dither_en_in) begin
      next_pix.red[1:0] = cap_pix.red[1:0] ^ dith_phase;
      next_pix.green[1:0] = cap_pix.green[1:0] ^ dith_phase;
      next_pix.blue[1:0] = cap_pix.blue[1:0] ^ dith_phase;
    end
    if (panel_6bit_in) begin
      next_pix.red[1:0] = next_pix.red[1:0] & ~ssc_pkg::SSC_LSB_MASK;
      next_pix.green[1:0] = next_pix.green[1:0] & ~ssc_pkg::SSC_LSB_MASK;
      next_pix.blue[1:0] = next_pix.blue[1:0] & ~ssc_pkg::SSC_LSB_MASK;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dith_phase <= 2'h0;
      pixel_out <= '0;
      pixel_valid_out <= 1'b0;
      primary_capture_edge_out <= 1'b0;
      scaler_active_out <= 1'b0;
      bypass_out <= 1'b1;
      input_mode_ok_out <= 1'b0;
      active_sync_mode_out <= 2'h0;
      panel_hsync_out <= 1'b0;
      panel_vsync_out <= 1'b0;
      lvds_lanes_first_out <= 4'h0;
      lvds_lanes_second_out <= 4'h0;
      lvds_clock_first_out <= 1'b0;
      lvds_clock_second_out <= 1'b0;
      extra_edges_out <= 1'b0;
    end else begin
      dith_phase <= cap_valid ? dith_phase + 2'h1 : dith_phase;
      pixel_out <= next_pix;
      pixel_valid_out <= cap_valid;
      primary_capture_edge_out <= edge_sel;
      scaler_active_out <= scale_on;
      bypass_out <= !scale_on;
      input_mode_ok_out <= mode_ok;
      active_sync_mode_out <= cur_mode;
      panel_hsync_out <= (hcnt < out_hsync_width_in);
      panel_vsync_out <= (vcnt < out_vsync_width_in);
      lvds_lanes_first_out <= ssc_pkg::SSC_LANES_ON;
      lvds_clock_first_out <= vclk_lvl;
      // second lanes off at ground; all on at supply
      lvds_lanes_second_out <= (is_dual || is_sido) ? ssc_pkg::SSC_LANES_ON
                                                    : ssc_pkg::SSC_LANES_OFF;
      lvds_clock_second_out <= (is_dual || is_sido) ? vclk_lvl : 1'b0;
      extra_edges_out <= is_sido;
    end
  end

  // ---- assertions ----
  property p_dual_off;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      (port_strap_in == ssc_pkg::SSC_PORT_DUAL) [*2] |-> !scaler_active_out;
  endproperty
  a_dual_off: assert property (p_dual_off) else $error("scaler on in dual mode");

  property p_single_lanes;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      (port_strap_in == ssc_pkg::SSC_PORT_SINGLE) |=> lvds_lanes_second_out == 4'h0
        && !lvds_clock_second_out && lvds_lanes_first_out == 4'hf;
  endproperty
  a_single_lanes: assert property (p_single_lanes) else $error("lanes wrong");

  property p_unprog;
    @(posedge sys_clk_in) disable iff (!rstn_in) !programmed_in |=> bypass_out;
  endproperty
  a_unprog: assert property (p_unprog) else $error("scaling without programming");

  property p_lsb_low;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      panel_6bit_in |=> pixel_out.red[1:0] == 2'h0 && pixel_out.blue[1:0] == 2'h0;
  endproperty
  a_lsb_low: assert property (p_lsb_low) else $error("six-bit lsbs not low");

  property p_mode_hold;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      !frame_end && !(cur_mode == ssc_pkg::SSC_SYNC_FRAME && in_frame_start)
        |=> $stable(cur_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed mid frame");

  property p_legal_mode;
    @(posedge sys_clk_in) disable iff (!rstn_in) cur_mode != 2'h2;
  endproperty
  a_legal_mode: assert property (p_legal_mode) else $error("illegal sync mode");

  sequence s_opp_valid;
    opp_edge && de_s2;
  endsequence
  property p_capture;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      s_opp_valid |=> cap_valid ##1 pixel_valid_out;
  endproperty
  a_capture: assert property (p_capture) else $error("pixel not captured");

  property p_frame_restart;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      (cur_mode == ssc_pkg::SSC_SYNC_FRAME && in_frame_start) |=> vcnt == 12'h000;
  endproperty
  a_frame_restart: assert property (p_frame_restart) else $error("vsync not restarted");

  property p_line_lock;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      (cur_mode == ssc_pkg::SSC_SYNC_LINE && in_line_start) |=> hcnt == 12'h000;
  endproperty
  a_line_lock: assert property (p_line_lock) else $error("hsync not line locked");

  property p_sido;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      (port_strap_in != ssc_pkg::SSC_PORT_SIDO) |=> !extra_edges_out;
  endproperty
  a_sido: assert property (p_sido) else $error("extra edges outside sido");
endmodule

// ### logic/ssc_edge_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser followed by edge detection on the second flop
module ssc_edge_sync (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  logic meta;
  logic stable;
  logic prev;
  logic [2:0] armed;

  // first flop only feeds the second
  // edges are masked until prev holds a real pin sample: the flops leave reset low
  // while the pin may idle high, which would otherwise fake an edge
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
      armed <= 3'h0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else begin
      meta <= async_in;
      stable <= meta;
      prev <= stable;
      armed <= {armed[1:0], 1'b1};
      rise_out <= stable & ~prev & armed[2];
      fall_out <= ~stable & prev & armed[2];
    end
  end

  assign level_out = prev;
endmodule

// ### shared/ssc_pkg.sv
package ssc_pkg;
  // port-configuration strap decoded from a three-level pin
  typedef enum logic [1:0] {
    SSC_PORT_SINGLE = 2'h0, // strap at ground
    SSC_PORT_SIDO = 2'h1, // strap at half supply
    SSC_PORT_DUAL = 2'h3 // strap at supply
  } ssc_port_e;

  // synchronisation modes; gray codes along free -> line -> frame
  typedef enum logic [1:0] {
    SSC_SYNC_FREE = 2'h0,
    SSC_SYNC_LINE = 2'h1,
    SSC_SYNC_FRAME = 2'h3
  } ssc_sync_e;

  // host-programmed input timing
  typedef struct packed {
    logic [11:0] hsync_width;
    logic [11:0] vsync_width;
    logic [11:0] pixel_total;
    logic [11:0] line_total;
    logic [11:0] active_start;
    logic [11:0] active_end;
  } ssc_in_timing_s;

  // one 24-bit pixel
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } ssc_pixel_s;

  localparam int unsigned SSC_WORD_W = 12;
  localparam int unsigned SSC_CNT_W = 12;
  // single-port rate above which scaling is bypassed, in MHz
  localparam int unsigned SSC_BYPASS_MHZ = 108;
  localparam int unsigned SSC_SYS_MHZ = 250;
  // measurement window in system cycles; count of rising link edges gives rate
  localparam int unsigned SSC_MEAS_CYC = 250;
  localparam logic [11:0] SSC_BYPASS_EDGES =
    12'(SSC_BYPASS_MHZ * SSC_MEAS_CYC / SSC_SYS_MHZ);
  localparam logic [11:0] SSC_CNT_ONE = 12'h0001;
  localparam logic [11:0] SSC_CNT_ZERO = 12'h0000;
  localparam logic [1:0] SSC_LSB_MASK = 2'h3;
  localparam logic [3:0] SSC_LANES_ON = 4'hf;
  localparam logic [3:0] SSC_LANES_OFF = 4'h0;
endpackage
